// ===== ic2_consts.svh
/*
 * Register offsets, field positions, reset values and masks for the
 * second interrupt-control block.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
`ifndef IC2_CONSTS_SVH
`define IC2_CONSTS_SVH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define IC2_OFS_CTRL2     12'h000
`define IC2_OFS_FLAGS     12'h004
`define IC2_OFS_MASK      12'h008
`define IC2_OFS_TDIS      12'h00C

// -----------------------------------------------------------------------------
// Field positions, widths, masks and reset values
// -----------------------------------------------------------------------------
`define IC2_BIT_ALT_SEL   15
`define IC2_BIT_TDIS      14
`define IC2_NUM_EXT       5
`define IC2_POL_MASK      16'h001F
`define IC2_CTRL2_RESET   16'h0000
`define IC2_TDIS_W        14

`endif

// ===== ic2_pkg.sv
/*
 * Types for the second interrupt-control block.
 * Assumes ic2_consts.svh is available in the include path.
 */
package ic2_pkg;
    typedef logic [4:0]  ic2_ext_t;
    typedef logic [15:0] ic2_reg_t;
    typedef enum logic [2:0] {
        IC2_IDLE   = 3'b001,
        IC2_ACCESS = 3'b010,
        IC2_DONE   = 3'b100
    } ic2_apb_st_t;
endpackage : ic2_pkg

// ===== ic2_ctrl.sv
/*
 * Second interrupt-control register with APB access, edge polarity select
 * and edge detection for five external interrupt pins.
 * Assumes pins and APB signals are synchronous to i_clk at 40 MHz.
 */
`timescale 1ns/1ps
`include "ic2_consts.svh"

module ic2_ctrl (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [4:0]  i_ext_irq,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_alt_vector_table_sel,
    output logic      [4:0]  o_ext_irq_req,
    output logic             o_irq
);

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    logic                   alt_q;
    ic2_pkg::ic2_ext_t      pol_q;
    ic2_pkg::ic2_ext_t      flag_q;
    ic2_pkg::ic2_ext_t      mask_q;
    logic [`IC2_TDIS_W-1:0] tdis_cnt_q;
    ic2_pkg::ic2_ext_t      sync1_q;
    ic2_pkg::ic2_ext_t      sync2_q;
    ic2_pkg::ic2_ext_t      prev_q;
    ic2_pkg::ic2_ext_t      edge_d;
    ic2_pkg::ic2_apb_st_t   st_q;
    logic                   wr_en;
    logic                   rd_en;
    logic                   timed_irq_disable_active;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // -------------------------------------------------------------------------
    // APB slave: pready stands in the second cycle after the first access cycle.
    // -------------------------------------------------------------------------
    // Writes land at the edge that completes the transfer, the same edge at which the master sees pready.
    assign wr_en = (st_q == ic2_pkg::IC2_DONE) && i_psel && i_penable && i_pwrite;
    assign rd_en = (st_q == ic2_pkg::IC2_ACCESS) && !i_pwrite;
    assign timed_irq_disable_active = (tdis_cnt_q != '0);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= ic2_pkg::IC2_IDLE;
        end else begin
            case (st_q)
                ic2_pkg::IC2_IDLE: begin
                    if (i_psel && i_penable) begin
                        st_q <= ic2_pkg::IC2_ACCESS;
                    end
                end
                ic2_pkg::IC2_ACCESS: begin
                    st_q <= ic2_pkg::IC2_DONE;
                end
                ic2_pkg::IC2_DONE: begin
                    st_q <= ic2_pkg::IC2_IDLE;
                end
                default: begin
                    st_q <= ic2_pkg::IC2_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= (st_q == ic2_pkg::IC2_ACCESS);
            o_pslverr <= (st_q == ic2_pkg::IC2_ACCESS) && !(hit(i_paddr, `IC2_OFS_CTRL2) ||
                         hit(i_paddr, `IC2_OFS_FLAGS) || hit(i_paddr, `IC2_OFS_MASK) ||
                         hit(i_paddr, `IC2_OFS_TDIS));
            o_prdata  <= 32'h0000_0000;
            if (rd_en) begin
                case (i_paddr)
                    // Bits 13 to 5 are left at zero.
                    `IC2_OFS_CTRL2: o_prdata <= {16'h0000, alt_q, timed_irq_disable_active, 9'h000, pol_q};
                    `IC2_OFS_FLAGS: o_prdata <= {27'h0, flag_q};
                    `IC2_OFS_MASK:  o_prdata <= {27'h0, mask_q};
                    `IC2_OFS_TDIS:  o_prdata <= {18'h0, tdis_cnt_q};
                    default:        o_prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // -------------------------------------------------------------------------
    // Control register
    // -------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            alt_q <= 1'b0;
            pol_q <= 5'h00;
        end else if (wr_en && hit(i_paddr, `IC2_OFS_CTRL2)) begin
            alt_q <= i_pwdata[`IC2_BIT_ALT_SEL];
            pol_q <= i_pwdata[4:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_alt_vector_table_sel <= 1'b0;
        end else begin
            o_alt_vector_table_sel <= alt_q;
        end
    end

    // Timed disable: software loads a cycle count; the status bit stays set until it expires.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tdis_cnt_q <= '0;
        end else if (wr_en && hit(i_paddr, `IC2_OFS_TDIS)) begin
            tdis_cnt_q <= i_pwdata[`IC2_TDIS_W-1:0];
        end else if (tdis_cnt_q != '0) begin
            tdis_cnt_q <= tdis_cnt_q - 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // Pin synchroniser and edge detection
    // -------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            prev_q  <= 5'h00;
        end else begin
            sync1_q <= i_ext_irq;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // A polarity change alone produces no edge, since both terms compare prev_q with sync2_q; no flag clear is needed afterwards.
    always_comb begin
        edge_d = (pol_q & prev_q & ~sync2_q)
               | (~pol_q & ~prev_q & sync2_q);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ext_irq_req <= 5'h00;
        end else begin
            o_ext_irq_req <= edge_d;
        end
    end

    // -------------------------------------------------------------------------
    // Flags, mask and interrupt output; set wins over write-one-to-clear.
    // -------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flag_q <= 5'h00;
        end else if (wr_en && hit(i_paddr, `IC2_OFS_FLAGS)) begin
            flag_q <= (flag_q & ~i_pwdata[4:0]) | edge_d;
        end else begin
            flag_q <= flag_q | edge_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mask_q <= 5'h00;
        end else if (wr_en && hit(i_paddr, `IC2_OFS_MASK)) begin
            mask_q <= i_pwdata[4:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(flag_q & mask_q);
        end
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    chk_alt_sel_follow: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_en && hit(i_paddr, `IC2_OFS_CTRL2)) |-> ##2 o_alt_vector_table_sel == $past(i_pwdata[15], 2))
        else $error("alt table select did not follow write");
    chk_tdis_status: assert property (@(posedge i_clk) disable iff (i_rst)
        (rd_en && i_paddr == `IC2_OFS_CTRL2) |=> o_prdata[`IC2_BIT_TDIS] == $past(tdis_cnt_q != '0))
        else $error("timed disable status wrong");
    chk_mid_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(rd_en && i_paddr == `IC2_OFS_CTRL2) |-> o_prdata[13:5] == 9'h000)
        else $error("unimplemented bits not zero");
    chk_pol_store: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_en && hit(i_paddr, `IC2_OFS_CTRL2)) |=> pol_q == $past(i_pwdata[4:0]))
        else $error("polarity not stored");
    chk_fall_edge: assert property (@(posedge i_clk) disable iff (i_rst)
        (pol_q[0] && $past(pol_q[0]) && $fell(sync2_q[0])) |=> o_ext_irq_req[0])
        else $error("falling edge missed");
    chk_rise_edge: assert property (@(posedge i_clk) disable iff (i_rst)
        (!pol_q[0] && $past(!pol_q[0]) && $rose(sync2_q[0])) |=> o_ext_irq_req[0])
        else $error("rising edge missed");
    chk_flag_set: assert property (@(posedge i_clk) disable iff (i_rst)
        o_ext_irq_req[0] |-> flag_q[0])
        else $error("flag zero not set");
    chk_pulse_once: assert property (@(posedge i_clk) disable iff (i_rst)
        o_ext_irq_req[0] |=> !o_ext_irq_req[0])
        else $error("request pulse longer than one cycle");

endmodule : ic2_ctrl

// ===== ic2_pin_src.sv
/* Model of the outside signals on the five external interrupt pins.
   Assumes the bench sets the wanted levels; pins move just after a clock edge. */
`timescale 1ns/1ps
module ic2_pin_src (
    input  wire logic       i_clk,
    input  wire logic [4:0] i_level,
    output logic      [4:0] o_pin
);
    initial o_pin = 5'h00;
    // Levels change only after an edge, so the sync stage sees clean steps.
    always @(posedge i_clk) begin
        o_pin <= i_level;
    end
endmodule : ic2_pin_src

// ===== ic2_ctrl_tb.sv
/* Self-checking bench for ic2_ctrl: register access over APB, pin edges, flags.
   Assumes ic2_consts.svh on the include path and the pin model beside it. */
`timescale 1ns/1ps
`include "ic2_consts.svh"
module ic2_ctrl_tb;
    logic        clk    = 1'b0;
    logic        rst    = 1'b1;
    logic        psel   = 1'b0;
    logic        pen    = 1'b0;
    logic        pwr    = 1'b0;
    logic [11:0] paddr  = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [4:0]  lvl    = 5'h00;
    logic [31:0] prdata, rd;
    logic [4:0]  pin, req;
    logic        prdy, perr, alt, irq, err;
    int          error_cnt = 0;
    int          n_checks = 0;

    initial begin
        forever #12.5 clk = ~clk;
    end

    ic2_pin_src src (.i_clk(clk), .i_level(lvl), .o_pin(pin));
    ic2_ctrl dut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_ext_irq(pin), .o_prdata(prdata), .o_pready(prdy),
        .o_pslverr(perr), .o_alt_vector_table_sel(alt), .o_ext_irq_req(req), .o_irq(irq));

    // -------------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (prdy !== 1'b1 && k < 50);
        rd  = prdata;
        err = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
        if (k >= 50) begin
            error_cnt++;
            $display("BAD %0t apb answer missing", $time);
            wrap_up();
        end
    endtask : apb

    // Counts request pulses on pin n over eight cycles; other bits must stay quiet.
    task automatic edge_test(input int n, input logic v, input int exp);
        int hits;
        hits = 0;
        @(posedge clk);
        lvl[n] <= v;
        repeat (8) begin
            @(posedge clk);
            if (req[n] === 1'b1) hits++;
            if ((req & ~(5'h01 << n)) !== 5'h00) hits += 10;
        end
        chk(32'(hits), 32'(exp), "edge pulses");
    endtask : edge_test

    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `IC2_OFS_CTRL2, 32'h00000000);
        chk(rd, 32'h00000000, "ctrl2 reset");
        chk({31'h0, alt}, 32'h00000000, "alt reset");
        apb(1'b1, `IC2_OFS_CTRL2, 32'hFFFFFFFF);
        apb(1'b0, `IC2_OFS_CTRL2, 32'h00000000);
        chk(rd, 32'h0000801F, "ctrl2 readback");
        chk({31'h0, err}, 32'h00000000, "mapped slverr");
        chk({31'h0, alt}, 32'h00000001, "alt table set");
        apb(1'b1, `IC2_OFS_CTRL2, 32'h00000000);
        repeat (2) @(posedge clk);
        chk({31'h0, alt}, 32'h00000000, "alt table clear");
        $display("test registers done");
        for (int n = 0; n < 5; n++) begin
            edge_test(n, 1'b1, 1);
            edge_test(n, 1'b0, 0);
        end
        apb(1'b0, `IC2_OFS_FLAGS, 32'h00000000);
        chk(rd, 32'h0000001F, "flags set");
        chk({31'h0, irq}, 32'h00000000, "irq masked");
        apb(1'b1, `IC2_OFS_MASK, 32'h00000001);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h00000001, "irq raised");
        apb(1'b0, `IC2_OFS_MASK, 32'h00000000);
        chk(rd, 32'h00000001, "mask readback");
        apb(1'b1, `IC2_OFS_FLAGS, 32'h00000001);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h00000000, "irq cleared");
        apb(1'b0, `IC2_OFS_FLAGS, 32'h00000000);
        chk(rd, 32'h0000001E, "flag zero cleared");
        $display("test rising edges done");
        apb(1'b1, `IC2_OFS_CTRL2, 32'h0000001F);
        repeat (8) @(posedge clk);
        for (int n = 0; n < 5; n++) begin
            edge_test(n, 1'b1, 0);
            edge_test(n, 1'b0, 1);
        end
        $display("test falling edges done");
        apb(1'b1, `IC2_OFS_TDIS, 32'h0000001E);
        apb(1'b0, `IC2_OFS_CTRL2, 32'h00000000);
        chk(rd & 32'h00004000, 32'h00004000, "timed disable active");
        for (int k = 0; k < 30 && rd[14] === 1'b1; k++) apb(1'b0, `IC2_OFS_CTRL2, 32'h00000000);
        chk(rd, 32'h0000001F, "timed disable over");
        apb(1'b1, 12'h010, 32'hFFFFFFFF);
        chk({31'h0, err}, 32'h00000001, "unmapped write");
        apb(1'b0, 12'h010, 32'h00000000);
        chk({err, rd[30:0]}, 32'h80000000, "unmapped read");
        $display("test status and errors done");
        wrap_up();
    end
endmodule : ic2_ctrl_tb
